//--- mshbc_defs.vh
`ifndef MSHBC_DEFS_VH
`define MSHBC_DEFS_VH
// Register byte offsets
`define MSHBC_REG_CTRL      8'h00
`define MSHBC_REG_HOLD_CFG  8'h04
`define MSHBC_REG_STATUS    8'h08
`define MSHBC_REG_BLEND_CFG 8'h0C
// CTRL field positions
`define MSHBC_CTRL_GSTOP    0
`define MSHBC_CTRL_GHOLD    1
`define MSHBC_CTRL_PHOLD0   2
`define MSHBC_CTRL_PHOLD1   3
// Reset values
`define MSHBC_CTRL_RST      32'h00000000
`define MSHBC_HOLD_RST      32'h00000064
`define MSHBC_BLEND_RST     32'h00000000
// Hold ramp tick: one ms at 100 MHz
`define MSHBC_TICK_NS       1000000
`define MSHBC_CLK_NS        10
`define MSHBC_TICK_CYC      (`MSHBC_TICK_NS / `MSHBC_CLK_NS)
// Sequencer command codes
`define MSHBC_CMD_NONE      4'h0
`define MSHBC_CMD_BLEND     4'h1
`define MSHBC_CMD_CHAIN     4'h2
`define MSHBC_CMD_GEAR_GO   4'h3
`define MSHBC_CMD_GEAR_STOP 4'h4
`define MSHBC_CMD_JOG_STOP  4'h5
`define MSHBC_CMD_PSTOP     4'h6
`define MSHBC_CMD_MOVE      4'h7
`endif

//--- mshbc_top.v
`timescale 1ns/1ns
`include "mshbc_defs.vh"
module mshbc_top #(
    parameter TICK_CYC = `MSHBC_TICK_CYC,
    parameter VW       = 16
)(
    input  wire              clk_sys,
    input  wire              sys_rst,
    input  wire [7:0]        s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [7:0]        s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire              global_stop_in,
    input  wire              motion_only_halt,
    input  wire              global_hold_in,
    input  wire [1:0]        per_profile_hold_in,
    input  wire [1:0]        per_profile_halt,
    input  wire [3:0]        cmd_code,
    input  wire              cmd_valid,
    output wire              cmd_ready,
    input  wire              cmd_profile,
    input  wire              cmd_use_var,
    input  wire [3:0]        cmd_target_const,
    input  wire [3:0]        cmd_target_var,
    input  wire [VW-1:0]     cmd_ratio,
    input  wire              cmd_set_on,
    input  wire              prog_done,
    input  wire [15:0]       move_defined,
    input  wire [15:0]       move_synced,
    input  wire [3:0]        cur_move,
    input  wire [1:0]        jog_active,
    output reg               prog_halt_all_ff,
    output reg  [1:0]        prof_halt_ff,
    output reg  [1:0]        prof_hold_ff,
    output reg  [1:0]        prof_stop_pulse_ff,
    output reg  [1:0]        jog_stop_pulse_ff,
    output reg  [1:0]        gear_on_ff,
    output reg  [VW-1:0]     gear_ratio_ff,
    output reg               blend_go_ff,
    output reg               chain_go_ff,
    output reg  [3:0]        next_move_ff,
    output reg               next_decel_own_ff,
    output reg  [7:0]        time_scale_ff
);
////////////////////////////////////////////////////////////////////////////
// Input synchronisers for assignment pins
reg [6:0] sync1_ff;
reg [6:0] sync2_ff;
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        sync1_ff <= 7'h00;
        sync2_ff <= 7'h00;
    end
    else
    begin
        sync1_ff <= {per_profile_halt, per_profile_hold_in,
                     global_hold_in, motion_only_halt, global_stop_in};
        sync2_ff <= sync1_ff;
    end
end
wire       pin_gstop = sync2_ff[0];
wire       pin_mstop = sync2_ff[1];
wire       pin_ghold = sync2_ff[2];
wire [1:0] pin_phold = sync2_ff[4:3];
wire [1:0] pin_phalt = sync2_ff[6:5];
////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave
reg  [31:0] ctrl_ff;
reg  [31:0] hold_cfg_ff;
reg  [31:0] blend_cfg_ff;
reg         aw_got_ff;
reg         w_got_ff;
reg  [7:0]  awaddr_ff;
reg  [31:0] wdata_ff;
reg  [3:0]  wstrb_ff;
wire [31:0] status_w;
assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
assign s_axi_wready  = !w_got_ff && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
wire do_wr = aw_got_ff && w_got_ff && !s_axi_bvalid;
wire wr_ctrl = do_wr && awaddr_ff == `MSHBC_REG_CTRL;
wire prog_gstop_set;
wire prog_hold_wr;
function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer k;
    begin
        merge = old;
        for (k = 0; k < 4; k = k + 1)
            if (st[k])
                merge[k*8 +: 8] = nw[k*8 +: 8];
    end
endfunction
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        awaddr_ff    <= 8'h00;
        wdata_ff     <= 32'h00000000;
        wstrb_ff     <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= 2'b00;
        ctrl_ff      <= `MSHBC_CTRL_RST;
        hold_cfg_ff  <= `MSHBC_HOLD_RST;
        blend_cfg_ff <= `MSHBC_BLEND_RST;
    end
    else
    begin
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end
        if (do_wr)
        begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= 2'b00;
            case (awaddr_ff)
            `MSHBC_REG_CTRL:
                ctrl_ff <= merge(ctrl_ff, wdata_ff, wstrb_ff);
            `MSHBC_REG_HOLD_CFG:
                hold_cfg_ff <= merge(hold_cfg_ff, wdata_ff, wstrb_ff);
            `MSHBC_REG_BLEND_CFG:
                blend_cfg_ff <= merge(blend_cfg_ff, wdata_ff, wstrb_ff);
            `MSHBC_REG_STATUS:
                s_axi_bresp <= 2'b00;
            default:
                s_axi_bresp <= 2'b10;
            endcase
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
        // Program writes share CTRL; set wins over a bus clear
        if (prog_gstop_set)
            ctrl_ff[`MSHBC_CTRL_GSTOP] <= 1'b1;
        if (prog_hold_wr)
        begin
            case ({cmd_profile, cmd_target_const[0]})
            2'b00, 2'b01:
                if (cmd_target_const[1])
                    ctrl_ff[`MSHBC_CTRL_GHOLD] <= cmd_set_on;
                else
                    ctrl_ff[`MSHBC_CTRL_PHOLD0] <= cmd_set_on;
            default:
                ctrl_ff[`MSHBC_CTRL_PHOLD1] <= cmd_set_on;
            endcase
        end
    end
end
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h00000000;
        s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
        `MSHBC_REG_CTRL:      s_axi_rdata <= ctrl_ff;
        `MSHBC_REG_HOLD_CFG:  s_axi_rdata <= hold_cfg_ff;
        `MSHBC_REG_STATUS:    s_axi_rdata <= status_w;
        `MSHBC_REG_BLEND_CFG: s_axi_rdata <= blend_cfg_ff;
        default:
        begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
        end
        endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
end
////////////////////////////////////////////////////////////////////////////
// Effective stop and hold per profile
wire       g_stop = pin_gstop | ctrl_ff[`MSHBC_CTRL_GSTOP];
wire       g_hold = pin_ghold | ctrl_ff[`MSHBC_CTRL_GHOLD];
wire [1:0] p_hold = pin_phold |
                    {ctrl_ff[`MSHBC_CTRL_PHOLD1], ctrl_ff[`MSHBC_CTRL_PHOLD0]};
wire [1:0] eff_halt = {2{g_stop | pin_mstop}} | pin_phalt;
wire [1:0] eff_hold = {2{g_hold}} | p_hold;
////////////////////////////////////////////////////////////////////////////
// Hold ramp: time scale 255 = full rate, 0 = frozen
reg  [31:0] tick_cnt_ff;
reg  [15:0] ramp_cnt_ff;
wire        tick = tick_cnt_ff == TICK_CYC - 1;
wire [15:0] ramp_ms = hold_cfg_ff[15:0];
wire        any_hold = |eff_hold;
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        tick_cnt_ff   <= 32'h00000000;
        ramp_cnt_ff   <= 16'h0000;
        time_scale_ff <= 8'hFF;
    end
    else
    begin
        tick_cnt_ff <= tick ? 32'h00000000 : tick_cnt_ff + 32'h00000001;
        if (tick)
        begin
            // Same count both ways keeps time and distance symmetric
            if (any_hold && ramp_cnt_ff < ramp_ms)
                ramp_cnt_ff <= ramp_cnt_ff + 16'h0001;
            else if (!any_hold && ramp_cnt_ff != 16'h0000)
                ramp_cnt_ff <= ramp_cnt_ff - 16'h0001;
        end
        if (ramp_ms == 16'h0000 || ramp_cnt_ff >= ramp_ms)
            time_scale_ff <= any_hold ? 8'h00 : 8'hFF;
        else
            time_scale_ff <= 8'hFF - ramp_scale(ramp_cnt_ff, ramp_ms);
    end
end
function [7:0] ramp_scale;
    input [15:0] c;
    input [15:0] m;
    reg   [23:0] p;
    begin
        p = {c, 8'h00} / {8'h00, m};
        ramp_scale = p[7:0];
    end
endfunction
////////////////////////////////////////////////////////////////////////////
// Sequencer command handling
wire [3:0] tgt = cmd_use_var ? cmd_target_var : cmd_target_const;
wire       gear_busy = gear_on_ff[cmd_profile];
wire       is_motion = cmd_code == `MSHBC_CMD_BLEND ||
                       cmd_code == `MSHBC_CMD_CHAIN ||
                       cmd_code == `MSHBC_CMD_MOVE  ||
                       cmd_code == `MSHBC_CMD_GEAR_GO;
// Gear start on busy gear stalls until a stop or program end clears that gear; motion waits on hold or stop
assign cmd_ready = !g_stop &&
    !(cmd_code == `MSHBC_CMD_GEAR_GO && gear_busy) &&
    !(is_motion && (eff_hold[cmd_profile] | eff_halt[cmd_profile]));
wire take = cmd_valid && cmd_ready;
assign prog_gstop_set = take && cmd_code == 4'h8 && cmd_set_on;
assign prog_hold_wr   = take && cmd_code == 4'h9;
wire tgt_ok = move_defined[tgt] &&
              move_synced[tgt] == move_synced[cur_move];
assign status_w = {8'h00, time_scale_ff, 4'h0, eff_hold, eff_halt,
                   gear_on_ff, jog_active, g_stop, g_hold,
                   next_decel_own_ff, prog_halt_all_ff};
always @(posedge clk_sys or posedge sys_rst)
begin
    if (sys_rst)
    begin
        prog_halt_all_ff   <= 1'b0;
        prof_halt_ff       <= 2'b00;
        prof_hold_ff       <= 2'b00;
        prof_stop_pulse_ff <= 2'b00;
        jog_stop_pulse_ff  <= 2'b00;
        gear_on_ff         <= 2'b00;
        gear_ratio_ff      <= {VW{1'b0}};
        blend_go_ff        <= 1'b0;
        chain_go_ff        <= 1'b0;
        next_move_ff       <= 4'h0;
        next_decel_own_ff  <= 1'b0;
    end
    else
    begin
        prog_halt_all_ff   <= g_stop;
        prof_halt_ff       <= eff_halt;
        prof_hold_ff       <= eff_hold;
        prof_stop_pulse_ff <= 2'b00;
        jog_stop_pulse_ff  <= 2'b00;
        blend_go_ff        <= 1'b0;
        chain_go_ff        <= 1'b0;
        // Gearing ignores hold but not stop
        gear_on_ff <= gear_on_ff & ~eff_halt;
        if (take)
        begin
            case (cmd_code)
            `MSHBC_CMD_BLEND:
            begin
                next_move_ff      <= tgt;
                blend_go_ff       <= tgt_ok;
                chain_go_ff       <= !tgt_ok;
                next_decel_own_ff <= tgt_ok;
            end
            `MSHBC_CMD_CHAIN:
            begin
                next_move_ff      <= tgt;
                chain_go_ff       <= 1'b1;
                next_decel_own_ff <= 1'b0;
            end
            `MSHBC_CMD_GEAR_GO:
            begin
                gear_on_ff[cmd_profile] <= 1'b1;
                gear_ratio_ff           <= cmd_ratio;
            end
            `MSHBC_CMD_GEAR_STOP:
                gear_on_ff[cmd_profile] <= 1'b0;
            `MSHBC_CMD_JOG_STOP:
                jog_stop_pulse_ff[cmd_profile] <=
                    jog_active[cmd_profile];
            `MSHBC_CMD_PSTOP:
                prof_stop_pulse_ff[cmd_profile] <= 1'b1;
            default:
                next_move_ff <= next_move_ff;
            endcase
        end
        // Program end wins over a gear start, so a gear start taken in the same cycle is lost
        if (prog_done)
            gear_on_ff <= 2'b00;
    end
end
endmodule // mshbc_top

//--- mshbc_chk.sv
`timescale 1ns/1ns
module mshbc_chk (
    input wire        clk_sys, sys_rst, cmd_valid, cmd_ready, cmd_profile,
    input wire        cmd_use_var, prog_done, global_stop_in,
    input wire        prog_halt_all_ff, blend_go_ff, chain_go_ff,
    input wire [3:0]  cmd_code, cmd_target_const, cmd_target_var, cur_move,
    input wire [3:0]  next_move_ff,
    input wire [15:0] move_defined, move_synced,
    input wire [1:0]  prof_hold_ff, prof_stop_pulse_ff, gear_on_ff
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire [3:0] tgt = cmd_use_var ? cmd_target_var : cmd_target_const;
    wire take = cmd_valid && cmd_ready;
    wire fits = move_defined[tgt] && move_synced[tgt] == move_synced[cur_move];
    ////////////////////////////////////////
    a_blend_route: assert property (take && cmd_code == 4'h1 |=>
        blend_go_ff == $past(fits) && chain_go_ff == !$past(fits))
        else $error("blend routed wrongly");
    a_blend_target: assert property (take && cmd_code == 4'h1 |=>
        next_move_ff == $past(tgt)) else $error("blend target wrong");
    a_gear_start: assert property (take && cmd_code == 4'h3 && !prog_done
        |=> gear_on_ff[$past(cmd_profile)]) else $error("gear not on");
    a_gear_stall: assert property (gear_on_ff[0] && cmd_valid &&
        cmd_code == 4'h3 && !cmd_profile |-> !cmd_ready)
        else $error("second gear start taken");
    a_prog_end: assert property (prog_done |=> gear_on_ff == 2'b00)
        else $error("gear kept after program end");
    a_stop_prio: assert property (global_stop_in [*3] |=>
        prog_halt_all_ff && !cmd_ready) else $error("global stop late");
    a_hold_wait: assert property (cmd_valid && cmd_code == 4'h7 &&
        !cmd_profile ##1 prof_hold_ff[0] |-> $past(!cmd_ready))
        else $error("move taken during hold");
    a_pstop_pulse: assert property (take && cmd_code == 4'h6 |=>
        prof_stop_pulse_ff == ($past(cmd_profile) ? 2'b10 : 2'b01))
        else $error("profile stop pulse wrong");
    cover property (blend_go_ff);
    cover property (chain_go_ff);
    cover property (gear_on_ff[1] ##1 gear_on_ff == 2'b00);
endmodule // mshbc_chk
bind mshbc_top mshbc_chk u_mshbc_chk (.clk_sys, .sys_rst, .cmd_valid,
    .cmd_ready, .cmd_profile, .cmd_use_var, .prog_done, .global_stop_in,
    .prog_halt_all_ff, .blend_go_ff, .chain_go_ff, .cmd_code,
    .cmd_target_const, .cmd_target_var, .cur_move, .next_move_ff,
    .move_defined, .move_synced, .prof_hold_ff, .prof_stop_pulse_ff,
    .gear_on_ff);

//--- mshbc_seq_model.sv
`timescale 1ns/1ns
module mshbc_seq_model (
    input  wire        clk_sys,
    input  wire        cmd_ready,
    output reg  [3:0]  cmd_code,
    output reg         cmd_valid,
    output reg         cmd_profile,
    output reg         cmd_use_var,
    output reg  [3:0]  cmd_target_const,
    output reg  [3:0]  cmd_target_var,
    output reg  [15:0] cmd_ratio,
    output reg         cmd_set_on,
    output reg         prog_done
);
    initial {cmd_code, cmd_valid, cmd_profile, cmd_use_var, cmd_target_const,
        cmd_target_var, cmd_ratio, cmd_set_on, prog_done} = 0;
    ////////////////////////////////////////
    task issue(input [3:0] c, input p, input u, input [3:0] tc,
        input [3:0] tv, input on, output ok);
        integer n;
        reg [31:0] rn;
    begin
        rn = $urandom;
        cmd_code <= c;
        cmd_profile <= p;
        cmd_use_var <= u;
        cmd_target_const <= tc;
        cmd_target_var <= tv;
        cmd_set_on <= on;
        cmd_ratio <= rn[15:0];
        cmd_valid <= 1'b1;
        n = 0;
        ok = 1'b0;
        while (!ok && n < 20)
        begin
            @(posedge clk_sys);
            ok = cmd_ready;
            n = n + 1;
        end
        // A real sequencer would hang here; withdraw so the run goes on
        cmd_valid <= 1'b0;
        {cmd_code, cmd_target_const, cmd_target_var} <= ~{c, tc, tv};
    end
    endtask
    task end_prog;
    begin
        @(posedge clk_sys);
        prog_done <= 1'b1;
        @(posedge clk_sys);
        prog_done <= 1'b0;
    end
    endtask
endmodule // mshbc_seq_model

//--- mshbc_tb.sv
`timescale 1ns/1ns
module testbench;
    reg         clk_sys = 1'b0, sys_rst = 1'b1, ok, b;
    reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0, r;
    reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg         s_axi_arvalid = 0, s_axi_rready = 0, global_stop_in = 0;
    reg         motion_only_halt = 0, global_hold_in = 0;
    reg  [1:0]  per_profile_hold_in = 0, per_profile_halt = 0, jog_active = 0;
    reg  [15:0] move_defined = 0, move_synced = 0;
    reg  [3:0]  cur_move = 0, t;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire        s_axi_rvalid, cmd_valid, cmd_ready, cmd_profile, cmd_use_var;
    wire        cmd_set_on, prog_done, prog_halt_all_ff, blend_go_ff;
    wire        chain_go_ff;
    wire [1:0]  s_axi_rresp, prof_halt_ff, prof_hold_ff, prof_stop_pulse_ff;
    wire [1:0]  gear_on_ff, s_axi_bresp, jog_stop_pulse_ff;
    wire [7:0]  time_scale_ff;
    wire [31:0] s_axi_rdata;
    wire [3:0]  cmd_code, cmd_target_const, cmd_target_var, next_move_ff;
    wire [15:0] cmd_ratio;
    integer     miscompares = 0, tests_run = 0, i;
    reg  [33:0] rq[$];
    reg  [5:0]  gq[$];
    always #5 clk_sys = ~clk_sys;
    // Short hold tick keeps the ramp to about 1000 cycles
    mshbc_top #(.TICK_CYC(10)) u_mshbc_top (.clk_sys, .sys_rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .global_stop_in, .motion_only_halt, .global_hold_in,
        .per_profile_hold_in, .per_profile_halt, .cmd_code, .cmd_valid,
        .cmd_ready, .cmd_profile, .cmd_use_var, .cmd_target_const,
        .cmd_target_var, .cmd_ratio, .cmd_set_on, .prog_done, .move_defined,
        .move_synced, .cur_move, .jog_active, .prog_halt_all_ff,
        .prof_halt_ff, .prof_hold_ff, .prof_stop_pulse_ff,
        .jog_stop_pulse_ff, .gear_on_ff, .gear_ratio_ff(), .blend_go_ff,
        .chain_go_ff, .next_move_ff, .next_decel_own_ff(), .time_scale_ff);
    mshbc_seq_model u_mshbc_seq_model (.clk_sys, .cmd_ready, .cmd_code,
        .cmd_valid, .cmd_profile, .cmd_use_var, .cmd_target_const,
        .cmd_target_var, .cmd_ratio, .cmd_set_on, .prog_done);
    ////////////////////////////////////////
    task note(input [39:0] g, input [39:0] e);
    begin
        tests_run = tests_run + 1;
        if (g !== e)
        begin
            miscompares = miscompares + 1;
            $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e);
        end
    end
    endtask
    task chk_rd(input [33:0] g, input [33:0] e); note(g, e); endtask
    task chk_go(input [5:0] g, input [5:0] e); note(g, e); endtask
    task chk_lvl(input [1:0] g, input [1:0] e); note(g, e); endtask
    task chk_ts(input [7:0] g, input [7:0] e); note(g, e); endtask
    task conclude;
    begin
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    task pause(input integer k);
    begin
        repeat (k) @(posedge clk_sys);
        @(negedge clk_sys);
    end
    endtask
    task pins(input [6:0] v);
    begin
        @(posedge clk_sys);
        {global_stop_in, motion_only_halt, global_hold_in, per_profile_halt,
            per_profile_hold_in} <= v;
        pause(4);
    end
    endtask
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk_rd({s_axi_bresp, 32'h0}, {(a > 8'h0C) ? 2'b10 : 2'b00, 32'h0});
        s_axi_bready <= 1'b0;
    end
    endtask
    task rd(input [7:0] a, input [33:0] e);
    begin
        @(posedge clk_sys);
        rq.push_back(e);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    end
    endtask
    task iss(input [3:0] c, input p, input [3:0] tc, input on, input e);
    begin
        @(posedge clk_sys);
        u_mshbc_seq_model.issue(c, p, 1'b0, tc, ~tc, on, ok);
        chk_lvl(ok, e);
    end
    endtask
    always @(posedge clk_sys)
    begin
        if (s_axi_rvalid && s_axi_rready)
            chk_rd({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (blend_go_ff || chain_go_ff)
            chk_go({chain_go_ff, blend_go_ff, next_move_ff}, gq.pop_front());
    end
    initial
    begin
        #200000;
        miscompares = miscompares + 1;
        conclude;
    end
    ////////////////////////////////////////
    initial
    begin
        r = $urandom(17);
        r = $urandom;
        jog_active = r[1:0];
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(8'h00, 34'h0);
        rd(8'h04, 34'h64);
        wr(8'h0C, r);
        rd(8'h0C, {2'b00, r});
        rd(8'h10, {2'b10, 32'h0});
        wr(8'h10, 32'h0);
        $display("test registers done");
        for (i = 0; i < 8; i = i + 1)
        begin
            r = $urandom;
            t = r[3:0];
            r = $urandom;
            b = r[16 + t] && r[t] == r[i];
            gq.push_back({~b, b, t});
            @(posedge clk_sys);
            {move_defined, move_synced, cur_move} <= {r, i[3:0]};
            u_mshbc_seq_model.issue(4'h1, 1'b0, i[0], t ^ {4{i[0]}},
                ~t ^ {4{i[0]}}, 1'b0, ok);
        end
        $display("test blend done");
        iss(4'h3, 1'b0, 4'h0, 1'b0, 1'b1);
        iss(4'h3, 1'b0, 4'h0, 1'b0, 1'b0);
        iss(4'h4, 1'b0, 4'h0, 1'b0, 1'b1);
        pause(0);
        chk_lvl(gear_on_ff, 2'b00);
        iss(4'h4, 1'b0, 4'h0, 1'b0, 1'b1);
        iss(4'h3, 1'b1, 4'h0, 1'b0, 1'b1);
        pause(0);
        chk_lvl(gear_on_ff, 2'b10);
        u_mshbc_seq_model.end_prog;
        pause(0);
        chk_lvl(gear_on_ff, 2'b00);
        iss(4'h5, 1'b1, 4'h0, 1'b0, 1'b1);
        pause(0);
        chk_lvl(jog_stop_pulse_ff, {jog_active[1], 1'b0});
        $display("test gearing done");
        pins(7'b1000000);
        chk_lvl(prog_halt_all_ff, 1'b1);
        iss(4'h7, 1'b0, 4'h0, 1'b0, 1'b0);
        pins(7'b0100000);
        chk_lvl(prof_halt_ff, 2'b11);
        iss(4'h6, 1'b1, 4'h0, 1'b0, 1'b1);
        pins(7'b0001000);
        chk_lvl(prof_halt_ff, 2'b10);
        iss(4'h7, 1'b0, 4'h0, 1'b0, 1'b1);
        iss(4'h6, 1'b0, 4'h0, 1'b0, 1'b1);
        iss(4'h7, 1'b0, 4'h0, 1'b0, 1'b1);
        pins(7'b0000001);
        chk_lvl(prof_hold_ff, 2'b01);
        iss(4'h7, 1'b0, 4'h0, 1'b0, 1'b0);
        iss(4'h7, 1'b1, 4'h0, 1'b0, 1'b1);
        pins(7'b0010000);
        chk_lvl(prof_hold_ff, 2'b11);
        // Ramp of 100 ticks of 10 cycles each must have reached standstill
        pause(1010);
        chk_ts(time_scale_ff, 8'h00);
        pins(7'b0000000);
        chk_lvl(prof_hold_ff, 2'b00);
        pause(1010);
        chk_ts(time_scale_ff, 8'hFF);
        $display("test stops done");
        iss(4'h9, 1'b0, 4'h2, 1'b1, 1'b1);
        pause(5);
        chk_lvl(prof_hold_ff, 2'b11);
        rd(8'h00, 34'h2);
        iss(4'h9, 1'b0, 4'h2, 1'b0, 1'b1);
        pause(2);
        chk_lvl(prof_hold_ff, 2'b00);
        iss(4'h8, 1'b0, 4'h0, 1'b1, 1'b1);
        pause(2);
        chk_lvl(prog_halt_all_ff, 1'b1);
        rd(8'h00, 34'h1);
        wr(8'h00, 32'h0);
        pause(2);
        chk_lvl(prog_halt_all_ff, 1'b0);
        $display("test program control done");
        conclude;
    end
endmodule // testbench
